// File: logic/uttc_pkg.sv
// shared constants of the usb transfer tuning control block
// assumes a 32-bit register port with byte enables, offsets relative to the base address
package uttc_pkg;
    localparam logic [11:0] UTTC_TUNING_OFS     = 12'h06c;
    localparam int          UTTC_RING_OFF_BIT   = 1;
    localparam int          UTTC_EARLY_OFF_BIT  = 0;
    localparam logic [31:0] UTTC_TUNING_RESET   = 32'h0000_0000;
    localparam int          UTTC_LEN_W          = 11;
    localparam int          UTTC_LEVELS         = 6;
    // packet size from which each early-start level applies, largest first
    localparam logic [10:0] UTTC_WM_SIZE [UTTC_LEVELS] = '{11'h400, 11'h380, 11'h300, 11'h280, 11'h200, 11'h1c0};
    // early-start levels in bytes: 767, 639, 511, 383, 255, 191
    localparam logic [10:0] UTTC_WM_LEVEL[UTTC_LEVELS] = '{11'h2ff, 11'h27f, 11'h1ff, 11'h17f, 11'h0ff, 11'h0bf};
endpackage

// File: logic/uttc_out_if.sv
// carrier between the tuning top and the out-packet start gate
// assumes one clock domain; all signals on clock_in
`timescale 1ns/1ns
`default_nettype none
interface uttc_out_if;
    logic                              early_on;
    logic [uttc_pkg::UTTC_LEN_W-1:0]   fetched;
    logic [uttc_pkg::UTTC_LEN_W-1:0]   pkt_size;
    logic                              start_ok;
    modport top  (output early_on, output fetched, output pkt_size, input start_ok);
    modport gate (input early_on, input fetched, input pkt_size, output start_ok);
endinterface
`default_nettype wire

// File: logic/uttc_out_gate.sv
// decides when an out packet may start on the usb bus
// assumes fetched counts bytes of the current packet already taken from host memory
`timescale 1ns/1ns
`default_nettype none
module uttc_out_gate
(
    uttc_out_if.gate port_if
);
    import uttc_pkg::*;

    logic [UTTC_LEN_W-1:0] level;
    logic                  has_level;

    always_comb
    begin
        level     = port_if.pkt_size;
        has_level = 1'b0;
        // later matches override, so the largest qualifying size picks the level
        for (int i = UTTC_LEVELS - 1; i >= 0; i--)
        begin
            if (port_if.pkt_size >= UTTC_WM_SIZE[i])
            begin
                level     = UTTC_WM_LEVEL[i];
                has_level = 1'b1;
            end
        end
    end

    always_comb
    begin
        if (port_if.early_on && has_level)
        begin
            port_if.start_ok = (port_if.fetched >= level);
        end
        else
        begin
            // full packet in hand before sending, no underrun possible
            port_if.start_ok = (port_if.pkt_size != '0) && (port_if.fetched >= port_if.pkt_size);
        end
    end
endmodule // uttc_out_gate
`default_nettype wire

// File: logic/uttc_top.sv
// tuning register and throughput gates of the usb host controller
// assumes a single-cycle register port behind the pci target and pulses from the buffer datapaths
`timescale 1ns/1ns
`default_nettype none
module uttc_top
(
    input  wire logic                            clock_in,
    input  wire logic                            resetn_in,
    input  wire logic                            tuning_strap_pin_in,
    input  wire logic                            reg_wr_in,
    input  wire logic                            reg_rd_in,
    input  wire logic [11:0]                     reg_addr_in,
    input  wire logic [3:0]                      reg_be_in,
    input  wire logic [31:0]                     reg_wdata_in,
    output logic      [31:0]                     reg_rdata_out,
    output logic                                 reg_hit_out,
    input  wire logic                            in_pkt_received_in,
    input  wire logic                            in_pkt_to_host_in,
    output logic                                 in_start_ok_out,
    input  wire logic [uttc_pkg::UTTC_LEN_W-1:0] out_fetched_in,
    input  wire logic [uttc_pkg::UTTC_LEN_W-1:0] out_pkt_size_in,
    output logic                                 out_start_ok_out,
    output logic                                 ring_buffer_off_out,
    output logic                                 early_start_off_out
);
    import uttc_pkg::*;

    typedef enum logic [1:0]
    {
        UTTC_SYNC  = 2'b00,
        UTTC_WAIT  = 2'b01,
        UTTC_LOAD  = 2'b11,
        UTTC_RUN   = 2'b10
    } uttc_state_t;

    uttc_state_t state_r;
    uttc_state_t state_nxt;
    logic        strap_meta_r;
    logic        strap_r;
    logic [31:0] tuning_r;
    logic [31:0] tuning_nxt;
    logic [31:0] tuning_view;
    logic        hit;
    logic        ring_off;
    logic        early_off;
    logic        in_pending_r;
    logic        load_default;
    logic        wr_open;
    logic        rd_hit;
    logic        wr_hit;

    uttc_out_if out_if ();

    // strap is a board pin, two stages before use
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            strap_meta_r <= 1'b0;
            strap_r      <= 1'b0;
        end
        else
        begin
            strap_meta_r <= tuning_strap_pin_in;
            strap_r      <= strap_meta_r;
        end
    end

    // strap_r holds the pin only after the second edge, so the default loads on the third
    always_comb
    begin
        case (state_r)
            UTTC_SYNC: state_nxt = UTTC_WAIT;
            UTTC_WAIT: state_nxt = UTTC_LOAD;
            UTTC_LOAD: state_nxt = UTTC_RUN;
            UTTC_RUN:  state_nxt = UTTC_RUN;
            default:   state_nxt = UTTC_SYNC;
        endcase
    end

    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_r <= UTTC_SYNC;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // full 12-bit offset decode, no aliases of the tuning register
    assign hit          = (reg_addr_in == UTTC_TUNING_OFS);
    assign rd_hit       = reg_rd_in & hit;
    assign wr_hit       = reg_wr_in & hit;
    assign load_default = (state_r == UTTC_LOAD);
    // writes before the default load are dropped so the strap value is not lost
    assign wr_open      = (state_r == UTTC_RUN) & wr_hit;

    always_comb
    begin
        tuning_nxt = tuning_r;
        if (load_default)
        begin
            tuning_nxt[UTTC_RING_OFF_BIT]  = strap_r;
            tuning_nxt[UTTC_EARLY_OFF_BIT] = strap_r;
        end
        else if (wr_open)
        begin
            // reserved bits are stored as written; software keeps them at reset value
            for (int b = 0; b < 4; b++)
            begin
                if (reg_be_in[b])
                begin
                    tuning_nxt[b*8 +: 8] = reg_wdata_in[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tuning_r <= UTTC_TUNING_RESET;
        end
        else
        begin
            tuning_r <= tuning_nxt;
        end
    end

    assign ring_off  = tuning_r[UTTC_RING_OFF_BIT] | strap_r;
    assign early_off = tuning_r[UTTC_EARLY_OFF_BIT] | strap_r;

    // stored bits stay as written; the strap only masks what is seen
    always_comb
    begin
        tuning_view                     = tuning_r;
        tuning_view[UTTC_RING_OFF_BIT]  = ring_off;
        tuning_view[UTTC_EARLY_OFF_BIT] = early_off;
    end

    // acknowledge one cycle after any access to the tuning offset
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            reg_hit_out <= 1'b0;
        end
        else
        begin
            reg_hit_out <= rd_hit | wr_hit;
        end
    end

    // registered read data; unmapped offsets and write cycles read zero
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            reg_rdata_out <= 32'h0000_0000;
        end
        else
        begin
            reg_rdata_out <= rd_hit ? tuning_view : 32'h0000_0000;
        end
    end

    // an in packet stays pending until handed to host; a new arrival wins over the hand-over
    // one flag only: a second arrival before the hand-over is not counted
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            in_pending_r <= 1'b0;
        end
        else if (in_pkt_received_in)
        begin
            in_pending_r <= 1'b1;
        end
        else if (in_pkt_to_host_in)
        begin
            in_pending_r <= 1'b0;
        end
    end

    // ring on: next in may start at once; off: wait for the previous packet to reach host
    always_comb
    begin
        if (ring_off)
        begin
            in_start_ok_out = !in_pending_r;
        end
        else
        begin
            in_start_ok_out = 1'b1;
        end
    end

    assign out_if.early_on = !early_off;
    assign out_if.fetched  = out_fetched_in;
    assign out_if.pkt_size = out_pkt_size_in;

    uttc_out_gate u_out_gate
    (
        .port_if (out_if.gate)
    );

    assign out_start_ok_out    = out_if.start_ok;
    assign ring_buffer_off_out = ring_off;
    assign early_start_off_out = early_off;
endmodule // uttc_top
`default_nettype wire

// File: bench/uttc_sva.sv
// port assertions of the transfer tuning block
// assumes bind onto uttc_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module uttc_sva
(
    input  wire logic        clock_in,
    input  wire logic        resetn_in,
    input  wire logic        tuning_strap_pin_in,
    input  wire logic        reg_rd_in,
    input  wire logic [11:0] reg_addr_in,
    input  wire logic [31:0] reg_rdata_out,
    input  wire logic        reg_hit_out,
    input  wire logic        in_pkt_received_in,
    input  wire logic        in_start_ok_out,
    input  wire logic [10:0] out_fetched_in,
    input  wire logic [10:0] out_pkt_size_in,
    input  wire logic        out_start_ok_out,
    input  wire logic        ring_buffer_off_out,
    input  wire logic        early_start_off_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    wire logic rd_t = reg_rd_in && reg_addr_in == 12'h06c;
    AST_READ_HIT: assert property (rd_t |=> reg_hit_out)
        else $error("tuning read not acknowledged");
    AST_RING_READ: assert property (rd_t |=> reg_rdata_out[1] == $past(ring_buffer_off_out))
        else $error("ring off bit reads wrong");
    AST_EARLY_READ: assert property (rd_t |=> reg_rdata_out[0] == $past(early_start_off_out))
        else $error("early off bit reads wrong");
    // four samples cover the two-stage strap synchroniser
    AST_STRAP_RING: assert property (tuning_strap_pin_in [*4] |-> ring_buffer_off_out)
        else $error("strap high but ring buffering on");
    AST_STRAP_EARLY: assert property (tuning_strap_pin_in [*4] |-> early_start_off_out)
        else $error("strap high but early start on");
    AST_IN_NOW: assert property (!ring_buffer_off_out |-> in_start_ok_out)
        else $error("in start held with ring buffering on");
    AST_IN_WAIT: assert property (ring_buffer_off_out && in_pkt_received_in |=> !in_start_ok_out)
        else $error("in start allowed before host handoff");
    AST_OUT_1024: assert property (!early_start_off_out && out_pkt_size_in == 11'h400
        |-> out_start_ok_out == (out_fetched_in >= 11'd767)) else $error("1024 byte start level wrong");
    AST_OUT_FULL: assert property (early_start_off_out && out_pkt_size_in != 11'h0
        |-> out_start_ok_out == (out_fetched_in >= out_pkt_size_in)) else $error("out start before full packet");
endmodule // uttc_sva
bind uttc_top uttc_sva u_sva (.clock_in, .resetn_in, .tuning_strap_pin_in, .reg_rd_in, .reg_addr_in,
    .reg_rdata_out, .reg_hit_out, .in_pkt_received_in, .in_start_ok_out, .out_fetched_in,
    .out_pkt_size_in, .out_start_ok_out, .ring_buffer_off_out, .early_start_off_out);
`default_nettype wire

// File: bench/uttc_host_model.sv
// host software model issuing tuning register accesses
// assumes read data valid in the cycle after a strobe
`timescale 1ns/1ns
`default_nettype none
module uttc_host_model
(
    input  wire logic        clock_in,
    input  wire logic [31:0] rdata_in,
    output logic             wr_out,
    output logic             rd_out,
    output logic [11:0]      addr_out,
    output logic [3:0]       be_out,
    output logic [31:0]      wdata_out
);
    initial {wr_out, rd_out, addr_out, be_out, wdata_out} = '0;
    task automatic access(input logic w, input logic [11:0] a, input logic [1:0] d, output logic [31:0] q);
        @(negedge clock_in);
        {wr_out, rd_out, addr_out, be_out} = {w, !w, a, 4'hf};
        wdata_out = {30'h0, d};
        @(negedge clock_in);
        {wr_out, rd_out} = 2'b00;
        // stale data must not look valid once released
        wdata_out = ~wdata_out;
        q = rdata_in;
    endtask
endmodule // uttc_host_model
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the tuning register and transfer gates
// assumes the host model drives the register port at falling edges
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import uttc_pkg::*;
    logic        clock_in, resetn_in, strap, in_rx, in_host, wr, rd, hit, in_ok, out_ok, ring_off, early_off;
    logic [31:0] rdata, q, wdata;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [10:0] fet, size;
    int          fail_count = 0;
    int          num_checks = 0;
    integer      seed = 32'h9e87d2ca;
    uttc_top uut (.clock_in, .resetn_in, .tuning_strap_pin_in(strap), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_be_in(be), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit),
        .in_pkt_received_in(in_rx), .in_pkt_to_host_in(in_host), .in_start_ok_out(in_ok),
        .out_fetched_in(fet), .out_pkt_size_in(size), .out_start_ok_out(out_ok),
        .ring_buffer_off_out(ring_off), .early_start_off_out(early_off));
    uttc_host_model host (.clock_in, .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .addr_out(addr),
        .be_out(be), .wdata_out(wdata));
    initial
    begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic exp_out(input logic [10:0] s, input logic [10:0] f, input logic off);
        logic [10:0] lv = s;
        // below the smallest size no early level applies
        if (!off)
            for (int i = UTTC_LEVELS - 1; i >= 0; i--)
                if (s >= UTTC_WM_SIZE[i])
                    lv = UTTC_WM_LEVEL[i];
        return s != 11'h0 && f >= lv;
    endfunction
    task automatic reg_io(input logic w, input logic [11:0] a, input logic [1:0] d, input logic [31:0] e,
                          input logic h);
        host.access(w, a, d, q);
        chk("rdata", e, q);
        chk("hit", {31'h0, h}, {31'h0, hit});
    endtask
    task automatic do_reset(input logic s);
        strap = s;
        resetn_in = 1'b0;
        repeat (16) @(negedge clock_in);
        resetn_in = 1'b1;
        repeat (3) @(negedge clock_in);
    endtask
    initial
    begin
        #200000;
        fail_count++;
        finish_test;
    end
    initial
    begin
        {in_rx, in_host, fet, size} = '0;
        do_reset(1'b0);
        reg_io(1'b0, 12'h06c, 2'h0, 32'h0, 1'b1);
        reg_io(1'b1, 12'h06c, 2'h3, 32'h0, 1'b1);
        chk("off", 32'h3, {30'h0, ring_off, early_off});
        reg_io(1'b0, 12'h06c, 2'h0, 32'h3, 1'b1);
        reg_io(1'b1, 12'h068, 2'h0, 32'h0, 1'b0);
        reg_io(1'b0, 12'h070, 2'h0, 32'h0, 1'b0);
        reg_io(1'b1, 12'h06c, 2'h0, 32'h0, 1'b1);
        in_rx = 1'b1;
        @(negedge clock_in);
        in_rx = 1'b0;
        chk("in_ok", 32'h1, {31'h0, in_ok});
        in_host = 1'b1;
        reg_io(1'b1, 12'h06c, 2'h2, 32'h0, 1'b1);
        in_host = 1'b0;
        in_rx = 1'b1;
        @(negedge clock_in);
        in_rx = 1'b0;
        repeat (2) @(negedge clock_in);
        chk("in_ok", 32'h0, {31'h0, in_ok});
        in_host = 1'b1;
        @(negedge clock_in);
        in_host = 1'b0;
        chk("in_ok", 32'h1, {31'h0, in_ok});
        for (int m = 0; m < 2; m++)
        begin
            reg_io(1'b1, 12'h06c, m[1:0], 32'h0, 1'b1);
            for (int i = 0; i < 300; i++)
            begin
                size = i < 2 ? 11'h400 : 11'($unsigned($random(seed)) % 1025);
                fet = i < 2 ? 11'(766 + i) : 11'($unsigned($random(seed)) % (size + 1));
                @(negedge clock_in);
                chk("out_ok", {31'h0, exp_out(size, fet, m[0])}, {31'h0, out_ok});
            end
        end
        do_reset(1'b1);
        reg_io(1'b0, 12'h06c, 2'h0, 32'h3, 1'b1);
        strap = 1'b0;
        repeat (3) @(negedge clock_in);
        reg_io(1'b0, 12'h06c, 2'h0, 32'h3, 1'b1);
        chk("off", 32'h3, {30'h0, ring_off, early_off});
        strap = 1'b1;
        repeat (3) @(negedge clock_in);
        reg_io(1'b1, 12'h06c, 2'h0, 32'h0, 1'b1);
        reg_io(1'b0, 12'h06c, 2'h0, 32'h3, 1'b1);
        chk("off", 32'h3, {30'h0, ring_off, early_off});
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
